// ==== core/timer_pkg.sv ====
// Package for the reloadable timer: register map, field layout, modes.
// Assumes a 32-bit APB master and a single system clock domain.
package timer_pkg;

	// =========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_COUNT = 12'h004;
	localparam logic [11:0] OFS_RELOAD = 12'h008;
	localparam logic [11:0] OFS_PWM = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;

	// =========================================================
	// Control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_POL_BIT = 3;
	localparam int CTRL_PRESC_LSB = 4;
	localparam int CTRL_OUT_EN_BIT = 7;

	// Status field positions
	localparam int STAT_EVENT_BIT = 0;
	localparam int STAT_CAPT_BIT = 1;

	// =========================================================
	// Reset and restart values
	localparam logic [15:0] COUNT_RESET = 16'h0001;
	localparam logic [15:0] COUNT_RESTART = 16'h0001;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] PWM_RESET = 16'h0000;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// =========================================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_COUNTER = 2'h0,
		MODE_PWM = 2'h1,
		MODE_CAPTURE = 2'h2,
		MODE_COMPARE = 2'h3
	} timer_mode_t;

	// Control register as carried inside the block
	typedef struct packed {
		logic out_en;
		logic [2:0] presc_exp;
		logic polarity_edge_select;
		timer_mode_t mode;
		logic enable;
	} timer_ctrl_t;

	// Sticky status bits
	typedef struct packed {
		logic capture;
		logic event_hit;
	} timer_status_t;

endpackage

// ==== core/timer_core.sv ====
// 16-bit reloadable timer with counter, PWM, capture and compare modes.
// Assumes an APB master on i_clk and an asynchronous timer input pin.
`timescale 1ns/1ns

// Operation
// RULE_01 - Counter mode counts input pin edges; polarity bit picks rising or falling.
// RULE_02 - Counter mode skips the prescaler; every qualifying edge adds exactly one.
// RULE_03 - External input frequency must stay at most a quarter of system clock.
// RULE_04 - Counter mode at reload: interrupt, count becomes 0001h, counting goes on.
// RULE_05 - Counter mode with output enabled inverts output pin at each reload.
// RULE_06 - Polarity bit also sets initial output level, output enabled or not.
// RULE_07 - Written start count serves first pass only; reloads restart at 0001h.
// RULE_08 - PWM mode counts prescaled clocks, toggles output on PWM value match.
// RULE_09 - PWM mode continues to reload, then interrupts and restarts at 0001h.
// RULE_10 - PWM with polarity one: start high, low at match, high at reload.
// RULE_11 - PWM with polarity zero: start low, high at match, low at reload.
// RULE_12 - Software must program reload strictly above the PWM match value.
// RULE_13 - Capture mode copies count into PWM value register on selected edge.
// RULE_14 - Capture event interrupts and counting continues without reset.
// RULE_15 - Capture mode at reload value interrupts and keeps counting.
// RULE_16 - Software clears PWM value before capture to tell reload from capture.
// RULE_17 - Compare mode match with reload value interrupts, count not reloaded.
// RULE_18 - Compare mode with output enabled inverts output at each match.
// RULE_19 - Compare mode count FFFFh wraps to 0000h and keeps counting.
// RULE_20 - Software disables, configures, loads counts, sets pins, then enables.
// RULE_21 - System clocked modes divide clock by prescale of 1 to 128.
// RULE_22 - Input pin synchronised, edge found from consecutive samples, one pulse.
// RULE_23 - Mode field selects the four modes; enable bit gates all counting.
module timer_core
	import timer_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_timer_in,
	output logic o_timer_out,
	output logic o_timer_out_en,
	output logic o_timer_irq
);

	// =========================================================
	// Decode helpers
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == OFS_CTRL) || (addr == OFS_COUNT) || (addr == OFS_RELOAD) ||
			(addr == OFS_PWM) || (addr == OFS_STATUS);
	endfunction

	function automatic logic [CNT_W-1:0] merge_half(input logic [CNT_W-1:0] old_v,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [CNT_W-1:0] v;
		v = old_v;
		if (strb[0]) begin
			v[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			v[CNT_W-1:8] = wd[CNT_W-1:8];
		end
		merge_half = v;
	endfunction

	// =========================================================
	// State
	timer_ctrl_t ctrl_q;
	timer_ctrl_t ctrl_d;
	timer_status_t status_q;
	timer_status_t status_d;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] reload_q;
	logic [CNT_W-1:0] reload_d;
	logic [CNT_W-1:0] pwm_q;
	logic [CNT_W-1:0] pwm_d;
	logic [6:0] presc_q;
	logic [6:0] presc_d;
	logic out_q;
	logic out_d;
	logic irq_q;
	logic irq_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic sync1_q;
	logic sync2_q;
	logic sample_q;

	// =========================================================
	// APB decode
	wire access = i_psel & i_penable;
	wire mapped = is_mapped(i_paddr);
	wire wr = access & i_pwrite & mapped;
	// Read data is latched in the setup cycle, so it already
	// stands at the access edge where the master takes it
	wire rd_setup = i_psel & ~i_penable & ~i_pwrite;
	wire wr_ctrl = wr & (i_paddr == OFS_CTRL) & i_pstrb[0];
	wire wr_count = wr & (i_paddr == OFS_COUNT);
	wire wr_reload = wr & (i_paddr == OFS_RELOAD);
	wire wr_pwm = wr & (i_paddr == OFS_PWM);
	wire wr_status = wr & (i_paddr == OFS_STATUS) & i_pstrb[0];

	assign o_pready = 1'b1;
	assign o_pslverr = access & ~mapped;
	assign o_prdata = rdata_q;

	// =========================================================
	// Register read views, upper bits read as zero
	wire [31:0] view_ctrl = {24'h000000, ctrl_q};
	wire [31:0] view_count = {{(32-CNT_W){1'b0}}, count_q};
	wire [31:0] view_reload = {{(32-CNT_W){1'b0}}, reload_q};
	wire [31:0] view_pwm = {{(32-CNT_W){1'b0}}, pwm_q};
	wire [31:0] view_status = {30'h00000000, status_q};

	// =========================================================
	// Input pin edge detection
	// Sample flop resets low like an idle pin, so no false edge
	wire rise = sync2_q & ~sample_q; // RULE_22
	wire fall = ~sync2_q & sample_q; // RULE_22
	wire edge_hit = ctrl_q.polarity_edge_select ? fall : rise; // RULE_01

	// =========================================================
	// Prescaler
	// Divide by two to the exponent, 1 to 128
	wire [6:0] presc_top = 7'((8'h01 << ctrl_q.presc_exp) - 8'h01); // RULE_21
	wire presc_wrap = (presc_q == presc_top);
	wire run = ctrl_q.enable; // RULE_23
	wire is_counter = (ctrl_q.mode == MODE_COUNTER);
	wire is_pwm = (ctrl_q.mode == MODE_PWM);
	wire is_capture = (ctrl_q.mode == MODE_CAPTURE);
	wire is_compare = (ctrl_q.mode == MODE_COMPARE);
	wire tick = run & (is_counter ? edge_hit : presc_wrap); // RULE_02

	// =========================================================
	// Event decode
	// Reload seen on the tick where the count equals it
	wire at_reload = tick & (count_q == reload_q);
	wire restart = at_reload & (is_counter | is_pwm); // RULE_04 RULE_09
	wire pwm_match = tick & is_pwm & (count_q == pwm_q); // RULE_08
	wire compare_hit = at_reload & is_compare; // RULE_17
	wire capture_hit = run & is_capture & edge_hit; // RULE_13
	wire reload_event = at_reload & ~is_compare; // RULE_15
	wire any_event = reload_event | compare_hit | capture_hit;
	wire [CNT_W-1:0] count_inc = count_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE_19

	// =========================================================
	// Next-state logic
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.enable = i_pwdata[CTRL_EN_BIT];
			ctrl_d.mode = timer_mode_t'(i_pwdata[CTRL_MODE_LSB +: 2]); // RULE_23
			ctrl_d.polarity_edge_select = i_pwdata[CTRL_POL_BIT];
			ctrl_d.presc_exp = i_pwdata[CTRL_PRESC_LSB +: 3];
			ctrl_d.out_en = i_pwdata[CTRL_OUT_EN_BIT];
		end
	end

	// =========================================================
	// Prescaler count, held at zero while disabled or counting
	// pin edges, so each enable starts a full prescale period
	always_comb begin
		presc_d = presc_q;
		if (!run || is_counter || presc_wrap) begin
			presc_d = 7'h00;
		end else begin
			presc_d = presc_q + 7'h01;
		end
	end

	// =========================================================
	// Count, a software write wins over a tick in the same cycle
	always_comb begin
		count_d = count_q;
		if (wr_count) begin
			count_d = merge_half(count_q, i_pwdata, i_pstrb);
		end else if (restart) begin
			count_d = COUNT_RESTART; // RULE_07
		end else if (tick) begin
			count_d = count_inc; // RULE_14 RULE_15 RULE_17 RULE_19
		end
	end

	// =========================================================
	// Reload or compare value, written by software only
	always_comb begin
		reload_d = reload_q;
		if (wr_reload) begin
			reload_d = merge_half(reload_q, i_pwdata, i_pstrb);
		end
	end

	// =========================================================
	// PWM value, a capture wins over a software write
	always_comb begin
		pwm_d = pwm_q;
		if (capture_hit) begin
			pwm_d = count_q; // RULE_13
		end else if (wr_pwm) begin
			pwm_d = merge_half(pwm_q, i_pwdata, i_pstrb);
		end
	end

	// =========================================================
	// Output level, follows the polarity bit while disabled
	always_comb begin
		out_d = out_q;
		if (!run) begin
			out_d = ctrl_d.polarity_edge_select; // RULE_06
		end else if (is_pwm) begin
			if (restart) begin
				out_d = ctrl_q.polarity_edge_select; // RULE_10 RULE_11
			end else if (pwm_match) begin
				out_d = ~ctrl_q.polarity_edge_select; // RULE_10 RULE_11
			end
		end else if (is_counter && restart) begin
			out_d = ~out_q; // RULE_05
		end else if (compare_hit) begin
			out_d = ~out_q; // RULE_18
		end
	end

	// =========================================================
	// Sticky status, a hardware set wins over a write-one clear
	always_comb begin
		status_d = status_q;
		if (wr_status) begin
			if (i_pwdata[STAT_EVENT_BIT]) begin
				status_d.event_hit = 1'b0;
			end
			if (i_pwdata[STAT_CAPT_BIT]) begin
				status_d.capture = 1'b0;
			end
		end
		if (reload_event || compare_hit) begin
			status_d.event_hit = 1'b1;
		end
		if (capture_hit) begin
			status_d.capture = 1'b1;
		end
	end

	// One-cycle pulse per reload, compare or capture
	assign irq_d = any_event; // RULE_04 RULE_09 RULE_14 RULE_15 RULE_17

	// =========================================================
	// Read data, unmapped addresses read as zero
	always_comb begin
		rdata_d = rdata_q;
		if (rd_setup) begin
			case (i_paddr)
				OFS_CTRL: begin
					rdata_d = view_ctrl;
				end
				OFS_COUNT: begin
					rdata_d = view_count;
				end
				OFS_RELOAD: begin
					rdata_d = view_reload;
				end
				OFS_PWM: begin
					rdata_d = view_pwm;
				end
				OFS_STATUS: begin
					rdata_d = view_status;
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
	end

	// =========================================================
	// Registers
	// Pin is asynchronous: two flops before the edge compare
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sample_q <= 1'b0;
		end else begin
			sync1_q <= i_timer_in;
			sync2_q <= sync1_q; // RULE_22
			sample_q <= sync2_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_q <= CTRL_RESET;
			status_q <= 2'h0;
			presc_q <= 7'h00;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			presc_q <= presc_d;
			irq_q <= irq_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_q <= COUNT_RESET;
			reload_q <= RELOAD_RESET;
			pwm_q <= PWM_RESET;
		end else begin
			count_q <= count_d;
			reload_q <= reload_d;
			pwm_q <= pwm_d;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			out_q <= out_d;
			rdata_q <= rdata_d;
		end
	end

	// =========================================================
	// Pin outputs
	assign o_timer_out = out_q;
	assign o_timer_out_en = ctrl_q.out_en;
	assign o_timer_irq = irq_q;

endmodule

// ==== sim/timer_core_chk.sv ====
// Port checker for the timer block.
// Assumes it is bound onto timer_core and sees its ports only.
`timescale 1ns/1ns
module timer_core_chk
	import timer_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_timer_in,
	input wire logic o_timer_out,
	input wire logic o_timer_out_en,
	input wire logic o_timer_irq
);
	// =========================================================
	// Control shadow and pin history
	logic [7:0] c_q;
	logic [7:0] h_q;
	wire ctl_wr = i_psel && i_penable && i_pwrite && i_paddr == OFS_CTRL && i_pstrb[0];
	wire mapped = i_paddr inside {OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_PWM, OFS_STATUS};
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			c_q <= 8'h00;
			h_q <= 8'h00;
		end else begin
			if (ctl_wr) begin
				c_q <= i_pwdata[7:0];
			end
			h_q <= {h_q[6:0], i_timer_in};
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	ready_up_a: assert property (i_psel |-> o_pready) else $error("pready low");
	map_err_a: assert property (i_psel && i_penable && !mapped |-> o_pslverr) else $error("no slverr");
	err_phase_a: assert property (o_pslverr |-> i_psel && i_penable && !mapped) else $error("stray slverr");
	idle_level_a: assert property ((!c_q[0] && $stable(c_q)) [*2] |-> o_timer_out == c_q[3])
		else $error("idle level wrong");
	out_enable_a: assert property ($stable(c_q) |-> o_timer_out_en == c_q[7]) else $error("out_en wrong");
	off_quiet_a: assert property ((!c_q[0]) [*3] |-> !o_timer_irq) else $error("irq while off");
	toggle_irq_a: assert property (c_q[0] && $stable(c_q) && c_q[2:1] != 2'h1 && c_q[2:1] != 2'h2
		&& $changed(o_timer_out) |-> o_timer_irq) else $error("toggle without event");
	edge_count_a: assert property (o_timer_irq && c_q[0] && $stable(c_q) && c_q[2:1] == 2'h0
		|-> h_q != 8'h00 && h_q != 8'hFF) else $error("count without edge");
endmodule

bind timer_core timer_core_chk i_chk(.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_timer_in(i_timer_in), .o_timer_out(o_timer_out),
	.o_timer_out_en(o_timer_out_en), .o_timer_irq(o_timer_irq));

// ==== sim/timer_pin_src.sv ====
// Source driving the timer input pin with bursts of pulses.
// Assumes a start strobe and pulse count from the bench.
`timescale 1ns/1ns
module timer_pin_src (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [3:0] i_n,
	output logic o_pin,
	output logic o_busy
);
	// =========================================================
	// Eight clocks a pulse, idle low
	logic [6:0] c_q = 7'h00;
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			c_q <= {i_n, 3'h0};
		end else if (c_q != 7'h00) begin
			c_q <= c_q - 7'h01;
		end
	end
	assign o_pin = c_q[2];
	assign o_busy = c_q != 7'h00;
endmodule

// ==== sim/timer_core_tb.sv ====
// Self-checking bench for the timer block.
// Assumes timer_pkg, the checker and the pin source.
`timescale 1ns/1ns
module timer_core_tb
	import timer_pkg::*;
();
	// =========================================================
	// Stimulus and bus tasks
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, go = 1'h0, er;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0, rd_v, prdata;
	logic [3:0] strb = 4'hF, npul = 4'h0;
	logic pready, pslverr, pin, tout, toe, irq, busy;
	int num_errors = 0, cmp_count = 0;
	timer_core i_dut(.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
		.i_pwdata(wd), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_timer_in(pin), .o_timer_out(tout), .o_timer_out_en(toe), .o_timer_irq(irq));
	timer_pin_src i_src(.i_clk(clk), .i_go(go), .i_n(npul), .o_pin(pin), .o_busy(busy));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		er = pslverr;
		rd_v = prdata;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	function automatic logic [31:0] ctl(logic en, logic [1:0] m, logic p, logic [2:0] ps, logic oe);
		return (32'(en) << CTRL_EN_BIT) | (32'(m) << CTRL_MODE_LSB) | (32'(p) << CTRL_POL_BIT)
			| (32'(ps) << CTRL_PRESC_LSB) | (32'(oe) << CTRL_OUT_EN_BIT);
	endfunction
	task automatic cfg(logic [1:0] m, logic p, logic [2:0] ps, logic [15:0] s, logic [15:0] r, logic [15:0] w);
		xf(1'h1, OFS_CTRL, ctl(1'h0, m, p, ps, 1'h1));
		xf(1'h1, OFS_COUNT, 32'(s));
		xf(1'h1, OFS_RELOAD, 32'(r));
		xf(1'h1, OFS_PWM, 32'(w));
		chk("idle out", tout, p);
		chk("out enable", toe, 1'h1);
		xf(1'h1, OFS_CTRL, ctl(1'h1, m, p, ps, 1'h1));
	endtask
	task automatic pulses(int n);
		npul <= 4'(n);
		go <= 1'h1;
		@(posedge clk);
		go <= 1'h0;
		repeat (n * 8 + 8) @(posedge clk);
	endtask
	task automatic wirq(input logic p, output int n, output int t);
		n = 0;
		t = 0;
		do begin
			@(posedge clk);
			n++;
			if (tout !== p) t = 1;
		end while (irq !== 1'h1 && n < 3000);
		chk("irq", irq, 1'h1);
	endtask
	function automatic logic [16:0] cnt_exp(int k, logic [15:0] s, logic [15:0] r);
		logic [16:0] c;
		c = {1'h0, s};
		repeat (k) c = (c[15:0] == r) ? {~c[16], 16'h0001} : c + 17'h00001;
		return c;
	endfunction
	task automatic report_and_stop();
		if (num_errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	// =========================================================
	// Main sequence
	initial begin
		int k, n, t;
		logic [16:0] e;
		logic [15:0] r, s, p;
		logic [11:0] ofs[6] = '{OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_PWM, OFS_STATUS, 12'h014};
		void'($urandom(81));
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			xf(1'h0, ofs[i], 32'h0);
			chk("reset rd", rd_v, (i == 1) ? 32'(COUNT_RESET) : 32'h0);
			chk("slverr", er, i == 5);
		end
		for (int i = 0; i < 4; i++) begin
			k = $urandom_range(12, 1);
			r = 16'($urandom_range(5, 2));
			s = 16'($urandom_range(r, 1));
			cfg(2'h0, i[0], 3'($urandom_range(7, 1)), s, r, 16'h0);
			pulses(k);
			e = cnt_exp(k, s, r);
			xf(1'h0, OFS_COUNT, 32'h0);
			chk("count", rd_v, 32'(e[15:0]));
			chk("out", tout, e[16] ^ i[0]);
		end
		for (int i = 0; i < 2; i++) begin
			cfg(2'h1, i[0], 3'(i + 1), 16'h1, 16'h6, 16'h3);
			wirq(i[0], n, t);
			chk("pwm start", tout, i[0]);
			wirq(i[0], n, t);
			chk("period", n, 6 << (i + 1));
			chk("match", t, 1);
		end
		cfg(2'h2, 1'h0, 3'h0, 16'h1, 16'hFFFF, 16'h0);
		xf(1'h1, OFS_STATUS, 32'h3);
		repeat (50) @(posedge clk);
		pulses(1);
		xf(1'h0, OFS_PWM, 32'h0);
		p = rd_v[15:0];
		xf(1'h0, OFS_COUNT, 32'h0);
		chk("capture", p != 16'h0 && rd_v[15:0] > p, 1);
		xf(1'h0, OFS_STATUS, 32'h0);
		chk("cap flag", rd_v[STAT_CAPT_BIT], 1);
		cfg(2'h3, 1'h1, 3'h0, 16'hFFFE, 16'h2, 16'h0);
		wirq(1'h1, n, t);
		chk("cmp out", tout, 1'h0);
		xf(1'h0, OFS_COUNT, 32'h0);
		chk("no reload", rd_v > 32'h2 && rd_v < 32'h20, 1);
		report_and_stop();
	end
endmodule
